// >>> src/brf_pkg.sv
// Constants and types for the banked general register file
package brf_pkg;
   localparam int NIB_W       = 4;
   localparam int BYTE_W      = 8;
   localparam int ADDR_W      = 12;
   localparam int BANKS       = 4;
   localparam int REGS        = 8;
   localparam int WORDS       = 32;
   localparam int IDX_W       = 5;
   localparam int REG_W       = 3;
   localparam int BANK_W      = 2;
   localparam int PAIR_W      = 2;
   localparam logic [ADDR_W-1:0] REG_LO   = 12'h000;
   localparam logic [ADDR_W-1:0] REG_HI   = 12'h01F;
   localparam logic [ADDR_W-1:0] PERI_LO  = 12'hF80;
   localparam logic [ADDR_W-1:0] PERI_HI  = 12'hFFF;
   localparam logic [NIB_W-1:0]  NIB_RST  = 4'h0;
   localparam logic [BANK_W-1:0] BANK_RST = 2'h0;
   localparam logic [PAIR_W-1:0] PAIR_ACC = 2'h0;
   localparam logic [PAIR_W-1:0] PAIR_PRI = 2'h1;
   localparam logic [PAIR_W-1:0] PAIR_SEC = 2'h2;
   localparam logic [PAIR_W-1:0] PAIR_GEN = 2'h3;

   typedef enum logic [2:0] {
      BRF_NORMAL  = 3'b001,
      BRF_IN_ISR  = 3'b010,
      BRF_IN_NEST = 3'b100
   } brf_isr_t;
endpackage : brf_pkg

// >>> src/brf_regfile.sv
// Banked general register file with pair access and interrupt flag save
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RULE_01 - Four banks of eight nibble registers overlay data addresses 00H to 1FH.
// RULE_02 - Active bank equals enable flag ANDed with two-bit select value.
// RULE_03 - Bank n starts at 8n; pair low nibble even, high nibble odd.
// RULE_04 - Interrupt entry saves and loads enable flag; return restores it. Code does so for the first level only; nested levels keep the flag.
// RULE_05 - Single registers and four pairs usable as nibble or byte operands.
// RULE_06 - Alternate pairs come from active bank with bit zero inverted.
// RULE_07 - Byte pair: even address low nibble, odd address high nibble.
// RULE_08 - Direct and indirect data access for 1, 4 and 8 bit operands.
// RULE_09 - Peripherals at F80H to FFFH, reached only by memory accesses.
module brf_regfile (
   input  wire logic                           clock,
   input  wire logic                           rst_b,
   input  wire logic                           enableSet,
   input  wire logic                           enableClr,
   input  wire logic                           selectWr,
   input  wire logic [brf_pkg::BANK_W-1:0]     selectData,
   input  wire logic                           isrEnter,
   input  wire logic                           isrEnableNew,
   input  wire logic                           isrReturn,
   input  wire logic                           regWr,
   input  wire logic                           regWide,
   input  wire logic                           regAlt,
   input  wire logic [brf_pkg::REG_W-1:0]      regSel,
   input  wire logic [brf_pkg::PAIR_W-1:0]     pairSel,
   input  wire logic [brf_pkg::BYTE_W-1:0]     regWrData,
   input  wire logic                           memRd,
   input  wire logic                           memWr,
   input  wire logic [1:0]                     memSize,
   input  wire logic [2:0]                     memBit,
   input  wire logic [brf_pkg::ADDR_W-1:0]     memAddr,
   input  wire logic [brf_pkg::BYTE_W-1:0]     memWrData,
   output var  logic [brf_pkg::BYTE_W-1:0]     regRdData,
   output var  logic [brf_pkg::BYTE_W-1:0]     memRdData,
   output var  logic                           memHit,
   output var  logic                           periSel,
   output var  logic                           regbank_enable_flag,
   output var  logic [brf_pkg::BANK_W-1:0]     regbank_select_value,
   output var  logic [brf_pkg::BANK_W-1:0]     active_register_bank
);
   import brf_pkg::*;

   localparam logic [1:0] SZ_BIT  = 2'h0;
   localparam logic [1:0] SZ_NIB  = 2'h1;
   localparam logic [1:0] SZ_BYTE = 2'h2;

   logic                 rstSync1;
   logic                 rstSync2;
   logic [NIB_W-1:0]     file [WORDS];
   logic                 savedEnable;
   brf_isr_t             isrState;
   logic [BANK_W-1:0]    bankNow;
   logic [BANK_W-1:0]    altBank;
   logic [IDX_W-1:0]     regIdx;
   logic [IDX_W-1:0]     memIdx;
   logic                 memInRegs;
   logic                 next_enable;

   // Reset released through two stages
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rstSync1 <= 1'b0;
         rstSync2 <= 1'b0;
      end else begin
         rstSync1 <= 1'b1;
         rstSync2 <= rstSync1;
      end
   end

   // Word index of a bank, register slot
   function automatic logic [IDX_W-1:0] wordIdx(input logic [BANK_W-1:0] b,
                                                input logic [REG_W-1:0] r);
      wordIdx = {b, r}; // RULE_03
   endfunction : wordIdx

   // True for an address inside a window
   function automatic logic inRange(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] lo,
                                    input logic [ADDR_W-1:0] hi);
      inRange = (a >= lo) && (a <= hi);
   endfunction : inRange

   assign bankNow   = {BANK_W{regbank_enable_flag}} & regbank_select_value; // RULE_02
   assign altBank   = {bankNow[BANK_W-1:1], ~bankNow[0]}; // RULE_06
   assign regIdx    = regWide ? wordIdx(regAlt ? altBank : bankNow, {pairSel, 1'b0})
                              : wordIdx(bankNow, regSel); // RULE_05 RULE_07
   assign memInRegs = inRange(memAddr, REG_LO, REG_HI); // RULE_01
   assign memIdx    = memAddr[IDX_W-1:0];

   // Set beats clear if both arrive together
   always_comb begin
      next_enable = regbank_enable_flag;
      if (enableClr)
         next_enable = 1'b0;
      if (enableSet)
         next_enable = 1'b1;
   end

   // Enable flag with interrupt save and restore
   always_ff @(posedge clock or negedge rstSync2) begin
      if (!rstSync2) begin
         regbank_enable_flag <= 1'b0;
         savedEnable         <= 1'b0;
         isrState            <= BRF_NORMAL;
      end else begin
         regbank_enable_flag <= next_enable;
         case (isrState)
            BRF_NORMAL: begin
               if (isrEnter) begin
                  savedEnable         <= regbank_enable_flag; // RULE_04
                  regbank_enable_flag <= isrEnableNew; // RULE_04
                  isrState            <= BRF_IN_ISR;
               end
            end
            BRF_IN_ISR: begin
               if (isrReturn) begin
                  regbank_enable_flag <= savedEnable; // RULE_04
                  isrState            <= BRF_NORMAL;
               end else if (isrEnter) begin
                  // Only one saved copy; deeper nesting is software's job
                  isrState <= BRF_IN_NEST;
               end
            end
            BRF_IN_NEST: begin
               if (isrReturn)
                  isrState <= BRF_IN_ISR;
            end
            default: isrState <= BRF_NORMAL;
         endcase
      end
   end

   // Bank select value
   always_ff @(posedge clock or negedge rstSync2) begin
      if (!rstSync2)
         regbank_select_value <= BANK_RST;
      else if (selectWr)
         regbank_select_value <= selectData;
   end

   // Storage; register port write has priority over memory write
   always_ff @(posedge clock or negedge rstSync2) begin
      if (!rstSync2) begin
         for (int i = 0; i < WORDS; i++)
            file[i] <= NIB_RST;
      end else if (regWr) begin
         file[regIdx] <= regWrData[NIB_W-1:0]; // RULE_05
         if (regWide)
            file[regIdx + 5'h01] <= regWrData[BYTE_W-1:NIB_W]; // RULE_07
      end else if (memWr && memInRegs) begin
         case (memSize)
            SZ_BIT:  file[memIdx][memBit[1:0]] <= memWrData[0]; // RULE_08
            SZ_NIB:  file[memIdx] <= memWrData[NIB_W-1:0]; // RULE_08
            SZ_BYTE: begin
               file[{memIdx[IDX_W-1:1], 1'b0}] <= memWrData[NIB_W-1:0]; // RULE_08
               file[{memIdx[IDX_W-1:1], 1'b1}] <= memWrData[BYTE_W-1:NIB_W];
            end
            default: ;
         endcase
      end
   end

   // Registered read paths
   always_ff @(posedge clock or negedge rstSync2) begin
      if (!rstSync2) begin
         regRdData            <= {NIB_RST, NIB_RST};
         memRdData            <= {NIB_RST, NIB_RST};
         memHit               <= 1'b0;
         periSel              <= 1'b0;
         active_register_bank <= BANK_RST;
      end else begin
         active_register_bank <= bankNow;
         regRdData <= regWide ? {file[regIdx + 5'h01], file[regIdx]}
                              : {NIB_RST, file[regIdx]}; // RULE_05
         memHit    <= (memRd || memWr) && memInRegs;
         periSel   <= (memRd || memWr) && inRange(memAddr, PERI_LO, PERI_HI); // RULE_09
         if (memRd && memInRegs) begin
            case (memSize)
               SZ_BIT:  memRdData <= {7'h00, file[memIdx][memBit[1:0]]};
               SZ_NIB:  memRdData <= {NIB_RST, file[memIdx]};
               SZ_BYTE: memRdData <= {file[{memIdx[IDX_W-1:1], 1'b1}],
                                      file[{memIdx[IDX_W-1:1], 1'b0}]};
               default: memRdData <= 8'h00;
            endcase
         end
      end
   end

   property p_bank_and;
      @(posedge clock) disable iff (!rstSync2)
      active_register_bank == ($past(regbank_enable_flag) ? $past(regbank_select_value) : 2'h0);
   endproperty
   a_bank_and: assert property (p_bank_and) else $error("bank not enable AND select"); // RULE_02

   sequence s_enter;
      isrState == BRF_NORMAL && isrEnter;
   endsequence
   property p_isr_load;
      @(posedge clock) disable iff (!rstSync2)
      s_enter |=> regbank_enable_flag == $past(isrEnableNew) && savedEnable == $past(regbank_enable_flag);
   endproperty
   a_isr_load: assert property (p_isr_load) else $error("enable not saved and loaded"); // RULE_04

   property p_isr_restore;
      @(posedge clock) disable iff (!rstSync2)
      (isrState == BRF_IN_ISR && isrReturn) |=> regbank_enable_flag == $past(savedEnable);
   endproperty
   a_isr_restore: assert property (p_isr_restore) else $error("enable not restored"); // RULE_04

   property p_pair_read;
      @(posedge clock) disable iff (!rstSync2)
      (regWide && !regAlt && !regWr && !memWr) |=>
         regRdData == {file[{$past(bankNow), $past(pairSel), 1'b1}], file[{$past(bankNow), $past(pairSel), 1'b0}]};
   endproperty
   a_pair_read: assert property (p_pair_read) else $error("pair read wrong"); // RULE_07

   property p_alt_write;
      @(posedge clock) disable iff (!rstSync2)
      (regWr && regWide && regAlt) |=>
         file[{$past(bankNow[1]), ~$past(bankNow[0]), $past(pairSel), 1'b0}] == $past(regWrData[3:0]);
   endproperty
   a_alt_write: assert property (p_alt_write) else $error("alternate pair write wrong"); // RULE_06

   property p_reg_write;
      @(posedge clock) disable iff (!rstSync2)
      (regWr && !regWide) |=> file[{$past(bankNow), $past(regSel)}] == $past(regWrData[3:0]);
   endproperty
   a_reg_write: assert property (p_reg_write) else $error("nibble write wrong"); // RULE_05

   property p_mem_map;
      @(posedge clock) disable iff (!rstSync2)
      (memWr && !regWr && memSize == SZ_NIB && memAddr <= REG_HI) |=>
         file[$past(memAddr[4:0])] == $past(memWrData[3:0]);
   endproperty
   a_mem_map: assert property (p_mem_map) else $error("overlay write wrong"); // RULE_01

   property p_peri;
      @(posedge clock) disable iff (!rstSync2)
      (memRd && memAddr >= PERI_LO) |=> periSel && !memHit;
   endproperty
   a_peri: assert property (p_peri) else $error("peripheral decode wrong"); // RULE_09
endmodule : brf_regfile

`default_nettype wire

// >>> sim/brf_data_mem.sv
// Behavioural data memory and peripheral space beyond the register overlay
`timescale 1ns/1ps
`default_nettype none
module brf_data_mem
   import brf_pkg::*;
(
   input  wire logic                       clock,
   input  wire logic                       memRd,
   input  wire logic                       memWr,
   input  wire logic [brf_pkg::ADDR_W-1:0] memAddr,
   input  wire logic [brf_pkg::BYTE_W-1:0] memWrData,
   output var  logic [brf_pkg::BYTE_W-1:0] extRdData
);
   import brf_pkg::*;
   logic [NIB_W-1:0] ram [1024];
   logic             inRam;
   assign inRam = (memAddr > REG_HI) && (memAddr < 12'h400);
   // Overlay addresses belong to the register file, never stored here
   always_ff @(posedge clock) begin
      if (memWr && inRam) begin
         ram[memAddr[9:0]] <= memWrData[NIB_W-1:0];
      end
   end
   // Idle bus shows inverted last value so stale data is never trusted
   always_ff @(posedge clock) begin
      if (memRd && inRam) begin
         extRdData <= {4'h0, ram[memAddr[9:0]]};
      end else if (memRd && memAddr >= PERI_LO) begin
         extRdData <= 8'h5A;
      end else begin
         extRdData <= ~extRdData;
      end
   end
endmodule : brf_data_mem
`default_nettype wire

// >>> sim/banked_general_register_file_bench.sv
// Self-checking bench for the banked general register file
`timescale 1ns/1ps
`default_nettype none
module banked_general_register_file_bench;
   import brf_pkg::*;
   localparam logic [22:0] M_REG  = 23'h7F8000;
   localparam logic [22:0] M_MEMB = 23'h007F80;
   localparam logic [22:0] M_MEMN = 23'h000780;
   localparam logic [22:0] M_HIT  = 23'h000060;
   localparam logic [22:0] M_FLAG = 23'h00001F;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic enableSet, enableClr, selectWr, isrEnter, isrEnableNew, isrReturn;
   logic regWr, regWide, regAlt, memRd, memWr, memHit, periSel, regbank_enable_flag;
   logic [BANK_W-1:0] selectData, regbank_select_value, active_register_bank;
   logic [REG_W-1:0]  regSel;
   logic [PAIR_W-1:0] pairSel;
   logic [BYTE_W-1:0] regWrData, memWrData, regRdData, memRdData, v;
   logic [1:0]        memSize;
   logic [2:0]        memBit;
   logic [ADDR_W-1:0] memAddr;
   logic [NIB_W-1:0]  shadow [WORDS];
   logic [45:0]       expQ [$];
   logic [45:0]       ent;
   logic [22:0]       obs;
   logic              expectNow = 1'b0;
   logic              pend = 1'b0;
   int                n_errors = 0;
   int                num_checks = 0;
   int                seed = 32'h4ae8;
   int                t;
   always #20 clock = ~clock;
   brf_regfile brf_regfile_inst (.clock, .rst_b, .enableSet, .enableClr, .selectWr, .selectData,
      .isrEnter, .isrEnableNew, .isrReturn, .regWr, .regWide, .regAlt, .regSel, .pairSel,
      .regWrData, .memRd, .memWr, .memSize, .memBit, .memAddr, .memWrData, .regRdData,
      .memRdData, .memHit, .periSel, .regbank_enable_flag, .regbank_select_value,
      .active_register_bank);
   brf_data_mem brf_data_mem_inst (.clock, .memRd, .memWr, .memAddr, .memWrData, .extRdData());
   assign obs = {regRdData, memRdData, memHit, periSel, regbank_enable_flag,
                 regbank_select_value, active_register_bank};
   // Results show one edge after the request, so the note ripens on that same edge
   always @(posedge clock) pend <= expectNow;
   always @(negedge clock) begin
      if (pend) begin
         ent = expQ.pop_front();
         num_checks++;
         if ((obs & ent[45:23]) !== (ent[22:0] & ent[45:23])) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h want %h mask %h", $time, obs, ent[22:0], ent[45:23]);
         end
      end
   end
   function automatic logic [22:0] ob(input logic [7:0] r, input logic [7:0] m,
                                      input logic [6:0] f);
      return {r, m, f};
   endfunction : ob
   task automatic stop_test();
      if (n_errors == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test
   task automatic idle();
      {enableSet, enableClr, selectWr, isrEnter, isrReturn, regWr, memRd, memWr} = 8'h00;
   endtask : idle
   task automatic cyc(input logic [22:0] m, input logic [22:0] e);
      expectNow = |m;
      if (|m) expQ.push_back({m, e});
      @(posedge clock);
      @(negedge clock);
   endtask : cyc
   task automatic regAcc(input logic w, input logic wd, input logic al, input logic [2:0] s,
                         input logic [1:0] p, input logic [7:0] d, input logic [22:0] m,
                         input logic [22:0] e);
      {enableSet, enableClr, selectWr, isrEnter, isrReturn, memRd, memWr} = 7'h00;
      {regWr, regWide, regAlt, regSel, pairSel, regWrData} = {w, wd, al, s, p, d};
      cyc(m, e);
   endtask : regAcc
   task automatic memAcc(input logic w, input logic [1:0] sz, input logic [11:0] a,
                         input logic [7:0] d, input logic [22:0] m, input logic [22:0] e);
      {enableSet, enableClr, selectWr, isrEnter, isrReturn, regWr} = 6'h00;
      {memWr, memRd, memSize, memAddr, memWrData} = {w, !w, sz, a, d};
      cyc(m, e);
   endtask : memAcc
   task automatic setBank(input logic en, input logic [1:0] s);
      {isrEnter, isrReturn, regWr, memRd, memWr} = 5'h00;
      {enableSet, enableClr, selectWr, selectData} = {en, !en, 1'b1, s};
      cyc(23'h0, 23'h0);
      idle();
      cyc(M_FLAG, {18'h0, en, s, s & {2{en}}});
   endtask : setBank
   // Strobe order: set, clear, enter, new flag, return; one idle cycle lets the bank settle
   task automatic flagStep(input logic [4:0] s, input logic [6:0] f);
      {enableSet, enableClr, isrEnter, isrEnableNew, isrReturn} = s;
      cyc(23'h0, 23'h0);
      idle();
      cyc(M_FLAG, ob(8'h0, 8'h0, f));
   endtask : flagStep
   initial begin
      repeat (20000) @(posedge clock);
      n_errors++;
      $display("MISMATCH at %0t: run did not finish", $time);
      stop_test();
   end
   initial begin
      idle();
      {isrEnableNew, regWide, regAlt, selectData, regSel, pairSel, regWrData} = 18'h0;
      {memSize, memBit, memAddr, memWrData} = 25'h0;
      for (int i = 0; i < WORDS; i++) shadow[i] = NIB_RST;
      repeat (5) @(negedge clock);
      rst_b = 1'b1;
      repeat (4) @(negedge clock);
      cyc(23'h7FFFFF, 23'h0);
      setBank(1'b0, 2'h3);
      for (int b = 0; b < BANKS; b++) begin
         setBank(1'b1, b[1:0]);
         for (int r = 0; r < REGS; r++) begin
            v = 8'($random(seed));
            shadow[b * REGS + r] = v[3:0];
            regAcc(1'b1, 1'b0, 1'b0, r[2:0], 2'h0, v, 23'h0, 23'h0);
         end
      end
      for (int r = 0; r < REGS; r++) begin
         regAcc(1'b0, 1'b0, 1'b0, r[2:0], 2'h0, 8'h0, M_REG, ob({4'h0, shadow[24 + r]}, 8'h0, 7'h0));
      end
      for (int a = 0; a < WORDS; a++) begin
         memAcc(1'b0, 2'h1, a[11:0], 8'h0, M_MEMN | M_HIT, ob(8'h0, {4'h0, shadow[a]}, 7'h40));
      end
      setBank(1'b1, 2'h2);
      for (int k = 0; k < 8; k++) begin
         v = 8'($random(seed));
         t = (2 ^ (k & 1)) * REGS + 2 * (k >> 1);
         regAcc(1'b1, 1'b1, k[0], 3'h0, k[2:1], v, 23'h0, 23'h0);
         regAcc(1'b0, 1'b1, k[0], 3'h0, k[2:1], 8'h0, M_REG, ob(v, 8'h0, 7'h0));
         memAcc(1'b0, 2'h2, t[11:0], 8'h0, M_MEMB, ob(8'h0, v, 7'h0));
      end
      v = 8'($random(seed));
      memAcc(1'b1, 2'h1, 12'h015, v, 23'h0, 23'h0);
      regAcc(1'b0, 1'b0, 1'b0, 3'h5, 2'h0, 8'h0, M_REG, ob({4'h0, v[3:0]}, 8'h0, 7'h0));
      memBit = 3'h2;
      memAcc(1'b1, 2'h0, 12'h015, 8'h01, 23'h0, 23'h0);
      memAcc(1'b0, 2'h0, 12'h015, 8'h0, M_MEMB, ob(8'h0, 8'h01, 7'h0));
      regAcc(1'b0, 1'b0, 1'b0, 3'h5, 2'h0, 8'h0, M_REG, ob({4'h0, v[3:0] | 4'h4}, 8'h0, 7'h0));
      memAcc(1'b1, 2'h2, 12'h012, v, 23'h0, 23'h0);
      regAcc(1'b0, 1'b1, 1'b0, 3'h0, 2'h1, 8'h0, M_REG, ob(v, 8'h0, 7'h0));
      memAcc(1'b1, 2'h1, 12'h020, 8'h0F, M_HIT, 23'h0);
      memAcc(1'b1, 2'h1, PERI_LO, 8'h05, M_HIT, ob(8'h0, 8'h0, 7'h20));
      memAcc(1'b0, 2'h1, PERI_HI, 8'h00, M_HIT, ob(8'h0, 8'h0, 7'h20));
      memAcc(1'b0, 2'h1, 12'h000, 8'h0, M_MEMN | M_HIT, ob(8'h0, {4'h0, shadow[0]}, 7'h40));
      // Read above the overlay leaves the last overlay read data standing
      memAcc(1'b0, 2'h1, 12'h020, 8'h0, M_MEMN | M_HIT, ob(8'h0, {4'h0, shadow[0]}, 7'h00));
      setBank(1'b1, 2'h3);
      flagStep(5'b00100, 7'h0C);
      flagStep(5'b00001, 7'h1F);
      setBank(1'b0, 2'h3);
      flagStep(5'b01110, 7'h1F);
      flagStep(5'b00100, 7'h1F);
      flagStep(5'b00001, 7'h1F);
      flagStep(5'b00001, 7'h0C);
      flagStep(5'b00001, 7'h0C);
      flagStep(5'b11000, 7'h1F);
      stop_test();
   end
endmodule : banked_general_register_file_bench
`default_nettype wire
